// *** rtl/csf_pkg.sv ***
package csf_pkg;
    // ========================================
    // register map and field layout
    localparam logic [7:0] CSF_FLAGS_ADDR  = 8'h0a;
    localparam int         CSF_WIDTH       = 8;
    localparam int         CSF_CARRY_BIT   = 0;
    localparam int         CSF_NIBBLE_BIT  = 1;
    localparam int         CSF_ZERO_BIT    = 2;
    localparam int         CSF_WRAP_BIT    = 3;
    localparam int         CSF_SLEEP_BIT   = 4;
    localparam int         CSF_WDOG_BIT    = 5;
    localparam logic [7:0] CSF_ARITH_MASK  = 8'h0f;
    localparam logic [7:0] CSF_RESET_VAL   = 8'h00;
    localparam logic [3:0] CSF_NIBBLE_ZERO = 4'h0;
    localparam logic [7:0] CSF_BYTE_ZERO   = 8'h00;

    // ========================================
    // alu operation select
    typedef enum logic [3:0] {
        CSF_OP_NONE  = 4'h0,
        CSF_OP_ADD   = 4'h1,
        CSF_OP_ADC   = 4'h2,
        CSF_OP_SUB   = 4'h3,
        CSF_OP_SBC   = 4'h4,
        CSF_OP_LOGIC = 4'h5,
        CSF_OP_RLC   = 4'h6,
        CSF_OP_RRC   = 4'h7
    } csf_op_t;
endpackage

// *** rtl/csf_flag_calc.sv ***
`timescale 1ns/1ns
module csf_flag_calc
    import csf_pkg::*;
(
    // operands
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire csf_op_t    op,
    input  wire logic       carry_in,
    // results
    output logic [7:0]      result,
    output logic            carry_out,
    output logic            nibble_out,
    output logic            wrap_out,
    output logic            arith_op,
    output logic            rot_op
);
    // ========================================
    // combinational flag generation
    logic [4:0] lo_sum;
    logic [8:0] full_sum;
    logic [7:0] low7_sum;
    logic [7:0] bb;
    logic       cin;
    logic       sub;

    always_comb begin
        sub        = (op == CSF_OP_SUB) || (op == CSF_OP_SBC);
        bb         = sub ? ~b : b;
        // subtract is add of complement; carry in 1 means no borrow
        case (op)
            CSF_OP_SUB: cin = 1'b1;
            CSF_OP_ADC: cin = carry_in;
            CSF_OP_SBC: cin = carry_in;
            default:    cin = 1'b0;
        endcase
        lo_sum     = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
        full_sum   = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
        low7_sum   = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, cin};
        arith_op   = (op == CSF_OP_ADD) || (op == CSF_OP_ADC) || sub;
        rot_op     = (op == CSF_OP_RLC) || (op == CSF_OP_RRC);
        carry_out  = full_sum[8];
        nibble_out = lo_sum[4];
        wrap_out   = full_sum[8] ^ low7_sum[7];
        case (op)
            CSF_OP_LOGIC: result = a;
            CSF_OP_RLC:   result = {a[6:0], carry_in};
            CSF_OP_RRC:   result = {carry_in, a[7:1]};
            default:      result = full_sum[7:0];
        endcase
        if (op == CSF_OP_RLC) begin
            carry_out = a[7];
        end else if (op == CSF_OP_RRC) begin
            carry_out = a[0];
        end
    end
endmodule

// *** rtl/csf_status_reg.sv ***
`timescale 1ns/1ns
module csf_status_reg
    import csf_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // alu request
    input  wire csf_op_t    alu_op,
    input  wire logic [7:0] alu_a,
    input  wire logic [7:0] alu_b,
    // data memory access
    input  wire logic [7:0] mem_addr,
    input  wire logic       mem_wr,
    input  wire logic [7:0] mem_wdata,
    // core events
    input  wire logic       watchdog_clear_instruction,
    input  wire logic       sleep_instruction,
    input  wire logic       watchdog_expired,
    // outputs
    output logic [7:0]      alu_result,
    output logic [7:0]      mem_rdata,
    output logic [7:0]      processor_flags
);
    // ========================================
    // flag calculator
    logic [7:0] res;
    logic       c_o;
    logic       n_o;
    logic       w_o;
    logic       ar;
    logic       ro;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [7:0] res_r;
    logic [7:0] res_nxt;
    logic [7:0] rd_r;
    logic [7:0] rd_nxt;
    logic       hit;

    csf_flag_calc u_calc (
        .a          (alu_a),
        .b          (alu_b),
        .op         (alu_op),
        .carry_in   (flags_r[CSF_CARRY_BIT]),
        .result     (res),
        .carry_out  (c_o),
        .nibble_out (n_o),
        .wrap_out   (w_o),
        .arith_op   (ar),
        .rot_op     (ro)
    );

    // ========================================
    // next flag values; only the program counter is stacked elsewhere,
    // so nothing here saves or restores the flags on call or interrupt
    always_comb begin
        hit       = mem_wr && (mem_addr == CSF_FLAGS_ADDR);
        flags_nxt = flags_r;
        res_nxt   = res;
        // software write touches only arithmetic flags
        if (hit) begin
            flags_nxt = (flags_r & ~CSF_ARITH_MASK) | (mem_wdata & CSF_ARITH_MASK);
        end
        if (ar) begin
            flags_nxt[CSF_CARRY_BIT]  = c_o;
            flags_nxt[CSF_NIBBLE_BIT] = n_o;
            flags_nxt[CSF_WRAP_BIT]   = w_o;
        end
        if (ro) begin
            flags_nxt[CSF_CARRY_BIT] = c_o;
        end
        if (alu_op != CSF_OP_NONE && !ro) begin
            flags_nxt[CSF_ZERO_BIT] = (res == CSF_BYTE_ZERO);
        end
        // sleep and watchdog flags, expiry wins over clears
        if (watchdog_clear_instruction) begin
            flags_nxt[CSF_SLEEP_BIT] = 1'b0;
            flags_nxt[CSF_WDOG_BIT]  = 1'b0;
        end
        if (sleep_instruction) begin
            flags_nxt[CSF_SLEEP_BIT] = 1'b1;
            flags_nxt[CSF_WDOG_BIT]  = 1'b0;
        end
        if (watchdog_expired) begin
            flags_nxt[CSF_WDOG_BIT] = 1'b1;
        end
        flags_nxt[7:6] = 2'b00;
        rd_nxt = (mem_addr == CSF_FLAGS_ADDR) ? flags_r : CSF_BYTE_ZERO;
    end

    // registers, cleared on power-up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= CSF_RESET_VAL;
            res_r   <= CSF_RESET_VAL;
            rd_r    <= CSF_RESET_VAL;
        end else begin
            flags_r <= flags_nxt;
            res_r   <= res_nxt;
            rd_r    <= rd_nxt;
        end
    end

    assign processor_flags = flags_r;
    assign alu_result      = res_r;
    assign mem_rdata       = rd_r;

    // ========================================
    // checks
    a_top_zero: assert property (@(posedge clk) disable iff (!rst_n)
        flags_r[7:6] == 2'b00) else $error("upper bits set");
    a_write_keeps_wdog: assert property (@(posedge clk) disable iff (!rst_n)
        hit && !watchdog_clear_instruction && !sleep_instruction && !watchdog_expired
        |=> flags_r[5:4] == $past(flags_r[5:4])) else $error("write hit wdog");
    a_write_arith: assert property (@(posedge clk) disable iff (!rst_n)
        hit && alu_op == CSF_OP_NONE |=> flags_r[3:0] == $past(mem_wdata[3:0]))
        else $error("write lost");
    a_sleep_sets: assert property (@(posedge clk) disable iff (!rst_n)
        sleep_instruction |=> flags_r[CSF_SLEEP_BIT]) else $error("sleep flag");
    a_clear_sleep: assert property (@(posedge clk) disable iff (!rst_n)
        watchdog_clear_instruction && !sleep_instruction |=> !flags_r[CSF_SLEEP_BIT])
        else $error("sleep not cleared");
    a_expiry_sets: assert property (@(posedge clk) disable iff (!rst_n)
        watchdog_expired |=> flags_r[CSF_WDOG_BIT]) else $error("wdog flag");
    a_add_carry: assert property (@(posedge clk) disable iff (!rst_n)
        alu_op == CSF_OP_ADD |=> flags_r[CSF_CARRY_BIT]
        == (({1'b0, $past(alu_a)} + {1'b0, $past(alu_b)}) > 9'h0ff))
        else $error("carry wrong");
    a_zero_flag: assert property (@(posedge clk) disable iff (!rst_n)
        alu_op == CSF_OP_LOGIC |=> flags_r[CSF_ZERO_BIT] == ($past(alu_a) == 8'h00))
        else $error("zero wrong");
    a_rlc_carry: assert property (@(posedge clk) disable iff (!rst_n)
        alu_op == CSF_OP_RLC |=> flags_r[CSF_CARRY_BIT] == $past(alu_a[7])
        && alu_result[0] == $past(flags_r[CSF_CARRY_BIT])) else $error("rlc wrong");
    a_nibble: assert property (@(posedge clk) disable iff (!rst_n)
        alu_op == CSF_OP_ADD |=> flags_r[CSF_NIBBLE_BIT]
        == (({1'b0, $past(alu_a[3:0])} + {1'b0, $past(alu_b[3:0])}) > 5'h0f))
        else $error("nibble wrong");
    a_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        alu_op == CSF_OP_ADD |=> flags_r[CSF_WRAP_BIT]
        == (($past(alu_a[7]) == $past(alu_b[7])) && (alu_result[7] != $past(alu_a[7]))))
        else $error("wrap wrong");

    // ========================================
    // named steps shared by the read and hold checks
    sequence s_flags_addr;
        mem_addr == CSF_FLAGS_ADDR;
    endsequence
    sequence s_no_event;
        !watchdog_clear_instruction && !sleep_instruction && !watchdog_expired;
    endsequence
    sequence s_quiet;
        alu_op == CSF_OP_NONE && !mem_wr ##0 s_no_event;
    endsequence

    // subtract and carry-in forms of the carry flag
    a_sub_carry: assert property (@(posedge clk) disable iff (!rst_n)
        alu_op == CSF_OP_SUB
        |=> flags_r[CSF_CARRY_BIT] == ($past(alu_a) >= $past(alu_b)))
        else $error("sub carry wrong");
    a_adc_carry: assert property (@(posedge clk) disable iff (!rst_n)
        alu_op == CSF_OP_ADC |=> flags_r[CSF_CARRY_BIT]
        == (({1'b0, $past(alu_a)} + {1'b0, $past(alu_b)}
        + {8'h00, $past(flags_r[CSF_CARRY_BIT])}) > 9'h0ff))
        else $error("adc carry wrong");
    a_sbc_carry: assert property (@(posedge clk) disable iff (!rst_n)
        alu_op == CSF_OP_SBC |=> flags_r[CSF_CARRY_BIT]
        == ({1'b0, $past(alu_a)} >= ({1'b0, $past(alu_b)}
        + {8'h00, !$past(flags_r[CSF_CARRY_BIT])})))
        else $error("sbc carry wrong");
    // sums and differences handed to the result register
    a_add_result: assert property (@(posedge clk) disable iff (!rst_n)
        alu_op == CSF_OP_ADD |=> alu_result == 8'($past(alu_a) + $past(alu_b)))
        else $error("add result wrong");
    a_sub_result: assert property (@(posedge clk) disable iff (!rst_n)
        alu_op == CSF_OP_SUB |=> alu_result == 8'($past(alu_a) - $past(alu_b)))
        else $error("sub result wrong");
    // right rotate through carry, and rotates leave the other flags
    a_rrc_carry: assert property (@(posedge clk) disable iff (!rst_n)
        alu_op == CSF_OP_RRC |=> flags_r[CSF_CARRY_BIT] == $past(alu_a[0])
        && alu_result[CSF_WIDTH-1] == $past(flags_r[CSF_CARRY_BIT]))
        else $error("rrc wrong");
    a_rot_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        (alu_op == CSF_OP_RLC || alu_op == CSF_OP_RRC) && !mem_wr
        |=> flags_r[CSF_WRAP_BIT:CSF_NIBBLE_BIT]
        == $past(flags_r[CSF_WRAP_BIT:CSF_NIBBLE_BIT]))
        else $error("rotate touched flags");
    // nibble carry and signed wrap on subtract
    a_sub_nibble: assert property (@(posedge clk) disable iff (!rst_n)
        alu_op == CSF_OP_SUB
        |=> flags_r[CSF_NIBBLE_BIT] == ($past(alu_a[3:0]) >= $past(alu_b[3:0])))
        else $error("sub nibble wrong");
    a_sub_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        alu_op == CSF_OP_SUB |=> flags_r[CSF_WRAP_BIT]
        == (($past(alu_a[7]) != $past(alu_b[7])) && (alu_result[7] != $past(alu_a[7]))))
        else $error("sub wrap wrong");
    // zero flag follows every result except rotates; logic keeps carries
    a_arith_zero: assert property (@(posedge clk) disable iff (!rst_n)
        alu_op != CSF_OP_NONE && alu_op != CSF_OP_RLC && alu_op != CSF_OP_RRC
        |=> flags_r[CSF_ZERO_BIT] == (alu_result == CSF_BYTE_ZERO))
        else $error("arith zero wrong");
    a_logic_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        alu_op == CSF_OP_LOGIC && !mem_wr
        |=> flags_r[CSF_WRAP_BIT] == $past(flags_r[CSF_WRAP_BIT])
        && flags_r[CSF_NIBBLE_BIT:CSF_CARRY_BIT]
        == $past(flags_r[CSF_NIBBLE_BIT:CSF_CARRY_BIT]))
        else $error("logic touched carries");
    // watchdog flag clears, and alu work leaves both event flags
    a_clear_wdog: assert property (@(posedge clk) disable iff (!rst_n)
        watchdog_clear_instruction && !watchdog_expired |=> !flags_r[CSF_WDOG_BIT])
        else $error("wdog not cleared");
    a_sleep_wdog: assert property (@(posedge clk) disable iff (!rst_n)
        sleep_instruction && !watchdog_expired |=> !flags_r[CSF_WDOG_BIT])
        else $error("sleep kept wdog");
    a_alu_keeps_events: assert property (@(posedge clk) disable iff (!rst_n)
        alu_op != CSF_OP_NONE ##0 s_no_event
        |=> flags_r[CSF_WDOG_BIT:CSF_SLEEP_BIT]
        == $past(flags_r[CSF_WDOG_BIT:CSF_SLEEP_BIT]))
        else $error("alu touched event flags");
    // read path shows the flags one cycle after the address
    a_read_hit: assert property (@(posedge clk) disable iff (!rst_n)
        s_flags_addr |=> mem_rdata == $past(flags_r))
        else $error("read hit wrong");
    a_read_miss: assert property (@(posedge clk) disable iff (!rst_n)
        mem_addr != CSF_FLAGS_ADDR |=> mem_rdata == CSF_BYTE_ZERO)
        else $error("read miss wrong");
    a_read_top: assert property (@(posedge clk) disable iff (!rst_n)
        mem_rdata[CSF_WIDTH-1:CSF_WDOG_BIT+1] == 2'b00)
        else $error("read upper bits set");
    // with nothing asked of it the register holds; no restore on return
    a_flags_hold: assert property (@(posedge clk) disable iff (!rst_n)
        s_quiet |=> $stable(flags_r))
        else $error("flags moved unasked");
endmodule

// *** testbench/csf_core_model.sv ***
`timescale 1ns/1ns
// ========================================
// core sequencer model: decodes an event code into pulses that last as long as the code is held
module csf_core_model (
    // event code: 0 none, 1 clear, 2 sleep, 3 expiry
    input  wire logic [1:0] ev,
    // pulses to the status register
    output logic            clr_p,
    output logic            slp_p,
    output logic            exp_p
);
    // one pulse at a time, so no two events share a cycle
    assign clr_p = (ev == 2'h1);
    assign slp_p = (ev == 2'h2);
    assign exp_p = (ev == 2'h3);
endmodule

// *** testbench/csf_status_reg_tb.sv ***
`timescale 1ns/1ns
module csf_status_reg_tb;
    import csf_pkg::*;
    logic       clk = 0, rst_n = 0, wr = 0;
    csf_op_t    op = CSF_OP_NONE;
    logic [7:0] a = 0, b = 0, ad = 0, wd = 0, e = 0, res, rd, fl;
    logic [1:0] ev = 0;
    logic       cp, sp, xp;
    logic [31:0] r = 32'heb3f;
    int         n_errors = 0, cmp_count = 0;
    csf_core_model core_u (.ev(ev), .clr_p(cp), .slp_p(sp), .exp_p(xp));
    csf_status_reg dut_u (.clk(clk), .rst_n(rst_n), .alu_op(op), .alu_a(a), .alu_b(b),
        .mem_addr(ad), .mem_wr(wr), .mem_wdata(wd), .watchdog_clear_instruction(cp),
        .sleep_instruction(sp), .watchdog_expired(xp), .alu_result(res),
        .mem_rdata(rd), .processor_flags(fl));
    // ========================================
    // clock and reference model
    initial forever #50 clk = ~clk;
    function automatic logic [31:0] lfsr(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // returns {result, next flags}
    function automatic logic [15:0] alu(csf_op_t o, logic [7:0] x, y, f);
        logic [8:0] s;
        logic [7:0] bb, q, lo;
        logic [4:0] nb;
        logic       ci, sb;
        sb = (o == CSF_OP_SUB) || (o == CSF_OP_SBC);
        bb = sb ? ~y : y;
        ci = (o == CSF_OP_SUB) ? 1'b1 : ((o == CSF_OP_ADC || o == CSF_OP_SBC) ? f[0] : 1'b0);
        s = 9'(x) + 9'(bb) + 9'(ci);
        nb = 5'(x[3:0]) + 5'(bb[3:0]) + 5'(ci);
        lo = 8'(x[6:0]) + 8'(bb[6:0]) + 8'(ci);
        q = 8'h00;
        if (o >= CSF_OP_ADD && o <= CSF_OP_SBC) begin
            q = s[7:0];
            f[3:0] = {lo[7] ^ s[8], q == 8'h00, nb[4], s[8]};
        end else if (o == CSF_OP_LOGIC) begin
            q = x;
            f[2] = (x == 8'h00);
        end else if (o == CSF_OP_RLC) begin
            q = {x[6:0], f[0]};
            f[0] = x[7];
        end else if (o == CSF_OP_RRC) begin
            q = {f[0], x[7:1]};
            f[0] = x[0];
        end
        return {q, f};
    endfunction
    task automatic chk(string nm, logic [7:0] ex, logic [7:0] got);
        cmp_count++;
        if (got !== ex) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // one cycle: drive, predict, check after the edge
    task automatic step(csf_op_t o, logic [7:0] x, y, d, logic w, logic [7:0] v, logic [1:0] k);
        logic [15:0] p;
        op = o; a = x; b = y; ad = d; wr = w; wd = v; ev = k;
        if (w && d == CSF_FLAGS_ADDR) e[3:0] = v[3:0];
        p = alu(o, x, y, e);
        e = p[7:0];
        case (k)
            2'h1: e[5:4] = 2'h0;
            2'h2: e[5:4] = 2'h1;
            2'h3: e[5] = 1'b1;
            default: ;
        endcase
        @(posedge clk);
        #1;
        chk("flags", e, fl);
        if (o != CSF_OP_NONE) chk("result", p[15:8], res);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ========================================
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        #1 rst_n = 1;
        chk("reset", CSF_RESET_VAL, fl);
        step(CSF_OP_ADD, 8'hff, 8'h01, 0, 0, 0, 0);
        step(CSF_OP_SUB, 8'h80, 8'h01, 0, 0, 0, 0);
        step(CSF_OP_NONE, 0, 0, CSF_FLAGS_ADDR, 1, 8'hff, 2'h2);
        step(CSF_OP_NONE, 0, 0, CSF_FLAGS_ADDR, 0, 0, 0);
        chk("read_hit", e, rd);
        step(CSF_OP_NONE, 0, 0, 8'h0b, 0, 0, 0);
        chk("read_miss", 8'h00, rd);
        for (int k = 1; k < 4; k++) step(CSF_OP_NONE, 0, 0, 0, 0, 0, 2'(k));
        repeat (400) begin
            r = lfsr(r);
            if (r[27:24] == 4'h0) step(CSF_OP_NONE, 0, 0, CSF_FLAGS_ADDR, 1, r[23:16], 0);
            else step(csf_op_t'(r[2:0]), r[15:8], r[23:16], r[31:24], 0, 0, r[29:28]);
        end
        wrap_up();
    end
endmodule
